// ===== src/ofr_defines.svh
/*
 * Constants of the over-temperature fault response block: command codes,
 * field positions, reset values, response and retry encodings.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef OFR_DEFINES_SVH
`define OFR_DEFINES_SVH

// ------------------------------------------------------------------
// command codes
// ------------------------------------------------------------------
`define OFR_CMD_TRIP_THR      8'h4F
`define OFR_CMD_ACTION_CFG    8'h50

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define OFR_RST_TRIP_THR      16'hEBE8
`define OFR_RST_ACTION_CFG    8'h80
`define OFR_RST_TRIES         3'h0
`define OFR_RST_UNITS         8'h00

// ------------------------------------------------------------------
// response and retry encodings
// ------------------------------------------------------------------
`define OFR_RESP_IGNORE       2'h0
`define OFR_RESP_RUN_DELAY    2'h1
`define OFR_RESP_DISABLE      2'h2
`define OFR_RESP_RESUME_OK    2'h3
`define OFR_RETRY_NONE        3'h0
`define OFR_RETRY_FOREVER     3'h7

// ------------------------------------------------------------------
// linear format fields
// ------------------------------------------------------------------
`define OFR_LIN_EXP_HI        15
`define OFR_LIN_EXP_LO        11
`define OFR_LIN_MAN_HI        10
`define OFR_LIN_EXP_BIAS      5'h10
`define OFR_LIN_SIGN_EXT      37

// ------------------------------------------------------------------
// misc
// ------------------------------------------------------------------
`define OFR_UNIT_ONE          8'h01
`define OFR_TRY_ONE           3'h1
`define OFR_ZERO_BYTE         8'h00
`define OFR_ZERO_WORD         16'h0000

`endif

// ===== src/ofr_pkg.sv
/*
 * Types of the over-temperature fault response block.
 * Assumes ofr_defines.svh is on the include path.
 */
`include "ofr_defines.svh"

package ofr_pkg;

	typedef enum logic [2:0] {
		OFR_ST_OFF   = 3'b000,
		OFR_ST_RUN   = 3'b001,
		OFR_ST_DELAY = 3'b010,
		OFR_ST_HOLD  = 3'b011,
		OFR_ST_WAIT  = 3'b100,
		OFR_ST_TRY   = 3'b101,
		OFR_ST_LATCH = 3'b110
	} ofr_state_e;

	// action register layout, msb first
	typedef struct packed {
		logic [1:0] resp;
		logic [2:0] retry;
		logic [2:0] delay;
	} ofr_cfg_s;

	typedef struct packed {
		logic       fault;
		logic       latched;
		ofr_state_e state;
		logic [2:0] tries;
	} ofr_status_s;

endpackage

// ===== src/ofr_lin_cmp.sv
/*
 * Registered greater-or-equal compare of two linear-format values
 * (5-bit signed exponent, 11-bit signed mantissa).
 * Assumes both inputs come from logic on clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ofr_defines.svh"

module ofr_lin_cmp
	import ofr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] value,
	input  wire logic [15:0] limit,
	output logic             ge_ff
);

	// ------------------------------------------------------------------
	// linear to fixed point, scaled by 2^16
	// ------------------------------------------------------------------
	function automatic logic signed [47:0] lin_fix(input logic [15:0] v);
		logic signed [47:0] man;
		logic        [4:0]  sh;
		man = {{`OFR_LIN_SIGN_EXT{v[`OFR_LIN_MAN_HI]}}, v[`OFR_LIN_MAN_HI:0]};
		sh  = v[`OFR_LIN_EXP_HI:`OFR_LIN_EXP_LO] ^ `OFR_LIN_EXP_BIAS;
		lin_fix = man <<< sh;
	endfunction

	logic nxt_ge;

	always_comb begin
		nxt_ge = (lin_fix(value) >= lin_fix(limit));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ge_ff <= 1'b0;
		end else begin
			ge_ff <= nxt_ge;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// same exponent: the order is that of the signed mantissas
	trip_compare_a : assert property (
		value[`OFR_LIN_EXP_HI:`OFR_LIN_EXP_LO] == limit[`OFR_LIN_EXP_HI:`OFR_LIN_EXP_LO]
		|=> ge_ff == $past($signed(value[`OFR_LIN_MAN_HI:0]) >=
			$signed(limit[`OFR_LIN_MAN_HI:0])))
		else $error("trip flag disagrees with threshold compare");

endmodule

`default_nettype wire

// ===== src/ofr_core.sv
/*
 * Over-temperature fault response: trip threshold and action registers
 * reached by command code, fault detection and the response sequencer
 * that drives the output enable.
 * Assumes: temp_value and unit_tick come from logic on clk; unit_tick is a
 * one-cycle pulse per delay time unit set by the time-base register kept
 * elsewhere; on_cmd is an asynchronous pin level.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ofr_defines.svh"

module ofr_core
	import ofr_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  cmd_code,
	input  wire logic        wr_en,
	input  wire logic [15:0] wr_data,
	input  wire logic        rd_en,
	output logic      [15:0] rd_data_ff,
	input  wire logic [15:0] temp_value,
	input  wire logic        unit_tick,
	input  wire logic        on_cmd,
	input  wire logic        other_fault,
	input  wire logic        clear_fault,
	output logic             out_en_ff,
	output var ofr_status_s  status
);

	// ------------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------------
	logic [15:0] thr_ff;
	ofr_cfg_s    cfg_ff;
	ofr_state_e  st_ff;
	ofr_state_e  nxt_st;
	logic [7:0]  units_ff;
	logic [2:0]  tries_ff;
	logic        on_s1_ff;
	logic        on_s2_ff;
	logic        on_s3_ff;
	logic        on_ok_ff;
	logic        fault;
	logic        live;
	logic        expire;
	logic        cfg_wr;

	// ------------------------------------------------------------------
	// delay decode: 2^code units
	// ------------------------------------------------------------------
	function automatic logic [7:0] dly_units(input logic [2:0] code);
		dly_units = `OFR_UNIT_ONE << code;
	endfunction

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	assign cfg_wr = wr_en && (cmd_code == `OFR_CMD_ACTION_CFG);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			thr_ff <= `OFR_RST_TRIP_THR;
		end else if (wr_en && (cmd_code == `OFR_CMD_TRIP_THR)) begin
			thr_ff <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_ff <= ofr_cfg_s'(`OFR_RST_ACTION_CFG);
		end else if (cfg_wr) begin
			cfg_ff <= ofr_cfg_s'(wr_data[7:0]);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data_ff <= `OFR_ZERO_WORD;
		end else if (rd_en) begin
			case (cmd_code)
				`OFR_CMD_TRIP_THR: begin
					rd_data_ff <= thr_ff;
				end
				`OFR_CMD_ACTION_CFG: begin
					rd_data_ff <= {`OFR_ZERO_BYTE, cfg_ff};
				end
				default: begin
					rd_data_ff <= `OFR_ZERO_WORD;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// fault detection
	// ------------------------------------------------------------------
	ofr_lin_cmp u_cmp (
		.clk   (clk),
		.rst_n (rst_n),
		.value (temp_value),
		.limit (thr_ff),
		.ge_ff (fault)
	);

	// ------------------------------------------------------------------
	// control pin synchroniser
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_s1_ff <= 1'b0;
			on_s2_ff <= 1'b0;
			on_s3_ff <= 1'b0;
		end else begin
			on_s1_ff <= on_cmd;
			on_s2_ff <= on_s1_ff;
			on_s3_ff <= on_s2_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			on_ok_ff <= 1'b0;
		end else if (on_s2_ff == on_s3_ff) begin
			on_ok_ff <= on_s3_ff;
		end
	end

	// commanded off or shut down by another fault ends every sequence
	assign live = on_ok_ff && !other_fault;

	// ------------------------------------------------------------------
	// delay timer, shared by run-on and retry interval
	// ------------------------------------------------------------------
	// time unit is the tick from the time-base register logic
	assign expire = unit_tick && ((units_ff + `OFR_UNIT_ONE) == dly_units(cfg_ff.delay));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			units_ff <= `OFR_RST_UNITS;
		end else if (cfg_wr || (nxt_st != st_ff)) begin
			units_ff <= `OFR_RST_UNITS;
		end else if (unit_tick && (st_ff == OFR_ST_WAIT || st_ff == OFR_ST_DELAY)) begin
			units_ff <= units_ff + `OFR_UNIT_ONE;
		end
	end

	// ------------------------------------------------------------------
	// response sequencer
	// ------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		if (!live) begin
			nxt_st = OFR_ST_OFF;
		end else begin
			case (st_ff)
				OFR_ST_OFF: begin
					nxt_st = OFR_ST_RUN;
				end
				OFR_ST_RUN: begin
					if (fault) begin
						case (cfg_ff.resp)
							`OFR_RESP_IGNORE: begin
								nxt_st = OFR_ST_RUN;
							end
							`OFR_RESP_RUN_DELAY: begin
								nxt_st = OFR_ST_DELAY;
							end
							`OFR_RESP_DISABLE: begin
								nxt_st = (cfg_ff.retry == `OFR_RETRY_NONE) ?
									OFR_ST_LATCH : OFR_ST_WAIT;
							end
							default: begin
								nxt_st = OFR_ST_HOLD;
							end
						endcase
					end
				end
				OFR_ST_DELAY: begin
					if (expire) begin
						if (!fault) begin
							nxt_st = OFR_ST_RUN;
						end else if (cfg_ff.retry == `OFR_RETRY_NONE) begin
							nxt_st = OFR_ST_LATCH;
						end else begin
							nxt_st = OFR_ST_WAIT;
						end
					end
				end
				OFR_ST_HOLD: begin
					if (!fault) begin
						nxt_st = OFR_ST_RUN;
					end
				end
				OFR_ST_WAIT: begin
					if (expire) begin
						nxt_st = OFR_ST_TRY;
					end
				end
				OFR_ST_TRY: begin
					if (!fault) begin
						nxt_st = OFR_ST_RUN;
					end else if (cfg_ff.retry != `OFR_RETRY_FOREVER &&
						(tries_ff + `OFR_TRY_ONE) >= cfg_ff.retry) begin
						nxt_st = OFR_ST_LATCH;
					end else begin
						nxt_st = OFR_ST_WAIT;
					end
				end
				OFR_ST_LATCH: begin
					if (clear_fault) begin
						nxt_st = OFR_ST_RUN;
					end
				end
				default: begin
					nxt_st = OFR_ST_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= OFR_ST_OFF;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// failed attempts so far in the current sequence; not counted when the retry code is continuous (7)
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tries_ff <= `OFR_RST_TRIES;
		end else if (nxt_st == OFR_ST_RUN || nxt_st == OFR_ST_OFF) begin
			tries_ff <= `OFR_RST_TRIES;
		end else if (st_ff == OFR_ST_TRY && fault && cfg_ff.retry != `OFR_RETRY_FOREVER) begin
			tries_ff <= tries_ff + `OFR_TRY_ONE;
		end
	end

	// output on while running, in run-on delay, or during an attempt
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_en_ff <= 1'b0;
		end else begin
			out_en_ff <= (nxt_st == OFR_ST_RUN) || (nxt_st == OFR_ST_DELAY) ||
				(nxt_st == OFR_ST_TRY);
		end
	end

	assign status.fault   = fault;
	assign status.latched = (st_ff == OFR_ST_LATCH);
	assign status.state   = st_ff;
	assign status.tries   = tries_ff;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	thr_write_a : assert property (
		wr_en && cmd_code == `OFR_CMD_TRIP_THR |=> thr_ff == $past(wr_data))
		else $error("threshold write not stored");

	ignore_runs_a : assert property (
		st_ff == OFR_ST_RUN && cfg_ff.resp == `OFR_RESP_IGNORE && live
		|=> out_en_ff && st_ff == OFR_ST_RUN)
		else $error("ignore response interrupted the output");

	delay_end_a : assert property (
		st_ff == OFR_ST_DELAY && expire && fault && live &&
		cfg_ff.retry != `OFR_RETRY_NONE |=> st_ff == OFR_ST_WAIT && !out_en_ff)
		else $error("run-on delay end did not start retries");

	disable_now_a : assert property (
		st_ff == OFR_ST_RUN && cfg_ff.resp == `OFR_RESP_DISABLE && fault && live
		|=> !out_en_ff)
		else $error("disable response left output on");

	hold_resume_a : assert property (
		st_ff == OFR_ST_HOLD && live |-> (fault ##1 !out_en_ff) or (!fault ##1 out_en_ff))
		else $error("resume-when-ok output wrong");

	no_retry_a : assert property (
		st_ff == OFR_ST_RUN && cfg_ff.resp == `OFR_RESP_DISABLE &&
		cfg_ff.retry == `OFR_RETRY_NONE && fault && live |=> st_ff == OFR_ST_LATCH)
		else $error("no-retry setting did not latch off");

	retry_limit_a : assert property (
		st_ff == OFR_ST_TRY && fault && live && cfg_ff.retry != `OFR_RETRY_FOREVER &&
		tries_ff + `OFR_TRY_ONE == cfg_ff.retry |=> st_ff == OFR_ST_LATCH ##1 !out_en_ff)
		else $error("retry count not honoured");

	interval_a : assert property (
		st_ff == OFR_ST_WAIT && live && expire |=> st_ff == OFR_ST_TRY && out_en_ff)
		else $error("attempt not started at interval end");

	forever_retry_a : assert property (
		st_ff == OFR_ST_TRY && fault && live && cfg_ff.retry == `OFR_RETRY_FOREVER
		|=> st_ff == OFR_ST_WAIT)
		else $error("continuous retry stopped");

	timer_bound_a : assert property (
		st_ff == OFR_ST_WAIT || st_ff == OFR_ST_DELAY |-> units_ff < dly_units(cfg_ff.delay))
		else $error("delay timer overran decoded units");

	off_cmd_a : assert property (
		!live |=> st_ff == OFR_ST_OFF && !out_en_ff)
		else $error("command off not obeyed");

	cover_delay_c : cover property (st_ff == OFR_ST_DELAY ##1 st_ff == OFR_ST_WAIT);
	cover_resume_c : cover property (st_ff == OFR_ST_HOLD ##1 st_ff == OFR_ST_RUN);
	cover_latch_c : cover property (st_ff == OFR_ST_TRY ##1 st_ff == OFR_ST_LATCH);
	cover_success_c : cover property (st_ff == OFR_ST_TRY ##1 st_ff == OFR_ST_RUN);

endmodule

`default_nettype wire

// ===== verif/ofr_host_model.sv
/*
 * Management bus host model: writes and reads the block's registers by
 * command code through one-cycle strobes.
 * Assumes the bench calls wr and rd one at a time; all changes land on
 * the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module ofr_host_model
	import ofr_pkg::*;
(
	input  wire logic        clk,
	output logic      [7:0]  cmd_code,
	output logic             wr_en,
	output logic      [15:0] wr_data,
	output logic             rd_en,
	input  wire logic [15:0] rd_data_ff
);
	initial begin
		cmd_code = 8'h00;
		wr_en    = 1'b0;
		wr_data  = 16'h0000;
		rd_en    = 1'b0;
	end

	// released lines are scrambled, never left at the last value
	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		@(negedge clk);
		cmd_code = c;
		wr_data  = d;
		wr_en    = 1'b1;
		@(negedge clk);
		wr_en    = 1'b0;
		wr_data  = ~d;
		cmd_code = ~c;
	endtask

	task automatic rd(input logic [7:0] c, output logic [15:0] d);
		@(negedge clk);
		cmd_code = c;
		rd_en    = 1'b1;
		@(negedge clk);
		rd_en    = 1'b0;
		cmd_code = ~c;
		@(negedge clk);
		d = rd_data_ff;
	endtask
endmodule

`default_nettype wire

// ===== verif/over_temp_fault_response_test.sv
/*
 * Self-checking bench for ofr_core: registers, fault compare and every
 * response and retry code, with a counted restart spacing.
 * Assumes ofr_pkg, ofr_core and ofr_host_model are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none

module over_temp_fault_response_test
	import ofr_pkg::*;
;
	localparam logic [15:0] THR  = 16'h0064;
	localparam logic [15:0] HOT  = 16'h00C8;
	localparam logic [15:0] COOL = 16'h0032;

	logic        clk         = 1'b0;
	logic        rst_n       = 1'b0;
	logic [7:0]  cmd_code;
	logic        wr_en;
	logic [15:0] wr_data;
	logic        rd_en;
	logic [15:0] rd_data_ff;
	logic [15:0] temp_value  = 16'h0032;
	logic        unit_tick   = 1'b0;
	logic        on_cmd      = 1'b0;
	logic        other_fault = 1'b0;
	logic        clear_fault = 1'b0;
	logic        out_en_ff;
	ofr_status_s status;
	logic        prev_en     = 1'b0;
	int          rises       = 0;
	int          n_fail      = 0;
	int          comparisons = 0;
	int          cyc         = 0;
	logic [15:0] v;
	logic [15:0] got;
	logic [2:0]  d;
	int          base;
	int unsigned seed_v;

	always #50 clk = ~clk;

	ofr_host_model host (.clk(clk), .cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data),
		.rd_en(rd_en), .rd_data_ff(rd_data_ff));

	ofr_core uut (.clk(clk), .rst_n(rst_n), .cmd_code(cmd_code), .wr_en(wr_en),
		.wr_data(wr_data), .rd_en(rd_en), .rd_data_ff(rd_data_ff), .temp_value(temp_value),
		.unit_tick(unit_tick), .on_cmd(on_cmd), .other_fault(other_fault),
		.clear_fault(clear_fault), .out_en_ff(out_en_ff), .status(status));

	// counts restart attempts seen as output rises, sampled where settled
	always @(negedge clk) begin
		prev_en <= out_en_ff;
		if (out_en_ff === 1'b1 && prev_en === 1'b0)
			rises <= rises + 1;
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			complete_run();
		end
	end

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask

	// delay code to number of time units
	function automatic int units_of(input logic [2:0] code);
		return 1 << code;
	endfunction

	task automatic tick(input int n);
		repeat (n) begin
			@(negedge clk);
			unit_tick = 1'b1;
			@(negedge clk);
			unit_tick = 1'b0;
			settle(3);
		end
	endtask

	task automatic cfg(input logic [1:0] r, input logic [2:0] t, input logic [2:0] dl);
		host.wr(8'h50, {8'h00, r, t, dl});
	endtask

	task automatic recover();
		temp_value = COOL;
		@(negedge clk);
		clear_fault = 1'b1;
		@(negedge clk);
		clear_fault = 1'b0;
		settle(6);
		check("out_en_back", out_en_ff, 16'h0001);
	endtask

	initial begin
		seed_v = $urandom(32'hE221);
		settle(12);
		rst_n = 1'b1;
		// ------------------------------------------------------------
		// registers
		// ------------------------------------------------------------
		host.rd(8'h4F, v);
		check("thr_reset", v, 16'hEBE8);
		host.rd(8'h50, v);
		check("cfg_reset", v, 16'h0080);
		host.rd(8'h51, v);
		check("unmapped", v, 16'h0000);
		host.wr(8'h50, 16'hFF00);
		host.rd(8'h50, v);
		check("cfg_low_byte", v, 16'h0000);
		repeat (4) begin
			v = 16'($urandom);
			host.wr(8'h4F, v);
			host.rd(8'h4F, got);
			check("thr_rw", got, v);
		end
		for (int i = 0; i < 4; i++) begin
			base = $urandom;
			host.wr(8'h4F, 16'(base));
			host.rd(8'h4F, v);
			check("thr_rw", v, 16'(base));
		end
		host.wr(8'h4F, THR);
		on_cmd = 1'b1;
		settle(10);
		check("out_en_on", out_en_ff, 16'h0001);
		// ------------------------------------------------------------
		// ignore and resume codes, compare at the boundary
		// ------------------------------------------------------------
		cfg(2'h0, 3'h0, 3'h0);
		temp_value = HOT;
		tick(4);
		check("ignore_on", out_en_ff, 16'h0001);
		check("fault_flag", status.fault, 16'h0001);
		cfg(2'h3, 3'h0, 3'h0);
		temp_value = 16'h0063;
		settle(4);
		check("below_thr", out_en_ff, 16'h0001);
		temp_value = 16'h0832;
		settle(4);
		check("hold_off", out_en_ff, 16'h0000);
		check("hold_state", status.state, OFR_ST_HOLD);
		temp_value = COOL;
		settle(4);
		check("resume_on", out_en_ff, 16'h0001);
		// ------------------------------------------------------------
		// run on for the coded delay, then no retry
		// ------------------------------------------------------------
		d = 3'($urandom_range(2, 0));
		cfg(2'h1, 3'h0, d);
		temp_value = HOT;
		settle(40);
		check("no_tick_on", out_en_ff, 16'h0001);
		tick(units_of(d) - 1);
		check("delay_on", out_en_ff, 16'h0001);
		tick(1);
		check("delay_end", out_en_ff, 16'h0000);
		tick(3);
		check("no_retry", status.state, OFR_ST_LATCH);
		recover();
		// fault gone before the run-on ends, then run-on into one retry
		cfg(2'h1, 3'h0, 3'h1);
		temp_value = HOT;
		settle(4);
		tick(1);
		temp_value = COOL;
		settle(3);
		tick(1);
		check("delay_cleared", status.state, OFR_ST_RUN);
		check("delay_run", out_en_ff, 16'h0001);
		cfg(2'h1, 3'h1, 3'h0);
		temp_value = HOT;
		settle(4);
		tick(1);
		check("delay_retry", status.state, OFR_ST_WAIT);
		check("delay_off", out_en_ff, 16'h0000);
		tick(1);
		check("delay_latch", status.state, OFR_ST_LATCH);
		recover();
		// ------------------------------------------------------------
		// disable and retry, every finite count
		// ------------------------------------------------------------
		for (int r = 1; r <= 6; r++) begin
			d = 3'($urandom_range(1, 0));
			cfg(2'h2, 3'(r), d);
			temp_value = HOT;
			settle(4);
			check("disable_now", out_en_ff, 16'h0000);
			base = rises;
			for (int k = 1; k <= r; k++) begin
				tick(units_of(d) - 1);
				check("try_early", 16'(rises - base), 16'(k - 1));
				tick(1);
				check("try_count", 16'(rises - base), 16'(k));
			end
			check("tries_out", status.state, OFR_ST_LATCH);
			check("latched_off", out_en_ff, 16'h0000);
			check("latched_flag", status.latched, 16'h0001);
			check("tries_done", status.tries, 16'(r));
			recover();
		end
		// ------------------------------------------------------------
		// endless retry, stopped by another fault
		// ------------------------------------------------------------
		cfg(2'h2, 3'h7, 3'h0);
		temp_value = HOT;
		settle(4);
		base = rises;
		tick(9);
		check("endless", 16'(rises - base), 16'h0009);
		check("still_wait", status.state, OFR_ST_WAIT);
		check("endless_tries", status.tries, 16'h0000);
		other_fault = 1'b1;
		settle(3);
		check("other_off", out_en_ff, 16'h0000);
		check("other_state", status.state, OFR_ST_OFF);
		other_fault = 1'b0;
		temp_value = COOL;
		settle(5);
		check("restart", out_en_ff, 16'h0001);
		// reset in mid-run: output drops at once, threshold back to its reset value
		rst_n = 1'b0;
		settle(2);
		check("rst_out", out_en_ff, 16'h0000);
		rst_n = 1'b1;
		host.rd(8'h4F, v);
		check("rst_thr", v, 16'hEBE8);
		settle(10);
		check("rst_rerun", out_en_ff, 16'h0001);
		complete_run();
	end
endmodule

`default_nettype wire
